/* core/scaling_pkg.sv */
package scaling_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  // register pointer offsets
  localparam logic [7:0] OFS_OPERATING_SETUP = 8'h00;
  localparam logic [7:0] OFS_SHUNT_DROP = 8'h01;
  localparam logic [7:0] OFS_SUPPLY_LEVEL = 8'h02;
  localparam logic [7:0] OFS_LOAD_POWER = 8'h03;
  localparam logic [7:0] OFS_LOAD_CURRENT = 8'h04;
  localparam logic [7:0] OFS_SCALE_FACTOR = 8'h05;
  // values after reset
  localparam logic [15:0] SETUP_RST = 16'h4127;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] SCALE_RST = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
  // field positions
  localparam int SETUP_SOFT_RST_BIT = 15;
  localparam int SUPPLY_MSB_BIT = 15;
  // arithmetic constants
  localparam int CUR_SHIFT = 11;
  localparam logic [32:0] CUR_TRUNC_ADJ = 33'h0_0000_07FF;
  localparam logic [15:0] PWR_DIVISOR = 16'h4E20;
  localparam int PWR_DIVIDEND_W = 31;
  localparam logic [4:0] PWR_DIV_STEPS = 5'h1F;
  localparam logic [15:0] SAT_POS = 16'h7FFF;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  localparam logic [15:0] SAT_UNSIGNED = 16'hFFFF;
  typedef enum logic [0:0] {ST_IDLE, ST_DIVIDE} div_state_t;
endpackage : scaling_pkg

/* core/current_power_scaling_engine.sv */
// Functional notes
// [RULE1] capture shunt drop and supply level samples
// [RULE2] power step is 25 current steps, fixed
// [RULE3] current equals shunt times scale over 2048
// [RULE4] power equals current times supply over 20000
// [RULE5] unprogrammed scale keeps current and power zero
// [RULE6] each new sample refreshes current and power; a sample followed by another within 32 cycles never updates power
// [RULE7] supply level result weighs 1.25mV per count
// [RULE8] supply level result MSB always reads zero
// [RULE9] host derives scale from step and resistance
// [RULE10] host picks step from maximum current
// [RULE11] host may trim scale for calibration
// [RULE12] reset and soft reset clear the scale
// [RULE13] divisions truncate, fraction discarded
// [RULE14] new scale applies from next sample only
`timescale 1ns/10ps
module current_power_scaling_engine #(
  parameter int DATA_W = scaling_pkg::DATA_W,
  parameter int ADDR_W = scaling_pkg::ADDR_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] shunt_sample_i,
  input wire logic [DATA_W-2:0] supply_sample_i,
  input wire logic sample_valid_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic power_ready_o
);

  function automatic logic [15:0] sat_signed(input logic signed [21:0] v);
    if (v > $signed(22'(scaling_pkg::SAT_POS)))
      sat_signed = scaling_pkg::SAT_POS;
    else if (v < -$signed(22'(scaling_pkg::SAT_NEG)))
      sat_signed = scaling_pkg::SAT_NEG;
    else
      sat_signed = v[15:0];
  endfunction : sat_signed

  function automatic logic [15:0] sat_unsigned(input logic [30:0] v);
    if (v > 31'(scaling_pkg::SAT_UNSIGNED))
      sat_unsigned = scaling_pkg::SAT_UNSIGNED;
    else
      sat_unsigned = v[15:0];
  endfunction : sat_unsigned

  logic [15:0] setup_r;
  logic [15:0] shunt_r;
  logic [15:0] supply_r;
  logic [15:0] power_r;
  logic [15:0] current_r;
  logic [15:0] scale_r;
  logic [15:0] rdata_r;
  logic ready_r;
  scaling_pkg::div_state_t state_r;
  logic [4:0] step_r;
  logic [31:0] quot_r;
  logic [15:0] rem_r;

  // register access decode
  wire wr_setup = reg_wr_i && (reg_addr_i == scaling_pkg::OFS_OPERATING_SETUP);
  wire wr_scale = reg_wr_i && (reg_addr_i == scaling_pkg::OFS_SCALE_FACTOR);
  wire soft_rst = wr_setup && reg_wdata_i[scaling_pkg::SETUP_SOFT_RST_BIT];
  wire clear_all = !nrst_i || soft_rst;
  logic [15:0] rd_mux;
  always_comb
  begin
    case (reg_addr_i)
      scaling_pkg::OFS_OPERATING_SETUP: rd_mux = setup_r;
      scaling_pkg::OFS_SHUNT_DROP: rd_mux = shunt_r;
      scaling_pkg::OFS_SUPPLY_LEVEL: rd_mux = supply_r;
      scaling_pkg::OFS_LOAD_POWER: rd_mux = power_r;
      scaling_pkg::OFS_LOAD_CURRENT: rd_mux = current_r;
      scaling_pkg::OFS_SCALE_FACTOR: rd_mux = scale_r;
      default: rd_mux = scaling_pkg::UNMAPPED_READ;
    endcase
  end

  // current: signed shunt times unsigned scale, truncated toward zero
  wire signed [32:0] cur_prod = $signed(shunt_sample_i) * $signed({1'b0, scale_r});
  wire signed [32:0] cur_adj = cur_prod[32] ?
    33'(cur_prod + $signed(scaling_pkg::CUR_TRUNC_ADJ)) : cur_prod; // RULE13
  wire signed [21:0] cur_quot = 22'(cur_adj >>> scaling_pkg::CUR_SHIFT); // RULE3
  wire [15:0] current_nxt = (scale_r == scaling_pkg::SCALE_RST) ?
    scaling_pkg::RESULT_RST : sat_signed(cur_quot); // RULE5
  wire [15:0] cur_mag = current_nxt[15] ? 16'(-current_nxt) : current_nxt;
  wire [15:0] supply_nxt = {1'b0, supply_sample_i}; // RULE7 RULE8

  // power dividend: magnitude of current times supply level
  wire [30:0] pwr_dividend = 31'(cur_mag * supply_sample_i);
  // leading zero on the dividend so 32 steps leave the exact quotient
  wire [16:0] rem_shift = {rem_r, quot_r[31]};
  wire rem_ge = rem_shift >= 17'(scaling_pkg::PWR_DIVISOR);
  wire [15:0] rem_nxt = rem_ge ? 16'(rem_shift - 17'(scaling_pkg::PWR_DIVISOR)) : rem_shift[15:0];
  wire [31:0] quot_nxt = {quot_r[30:0], rem_ge};
  wire last_step = (state_r == scaling_pkg::ST_DIVIDE) && (step_r == scaling_pkg::PWR_DIV_STEPS);

  always_ff @(posedge clk_i)
  begin
    if (clear_all)
    begin
      setup_r <= scaling_pkg::SETUP_RST;
      scale_r <= scaling_pkg::SCALE_RST; // RULE12
    end
    else
    begin
      if (wr_setup)
        setup_r <= reg_wdata_i;
      if (wr_scale)
        scale_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (clear_all)
    begin
      shunt_r <= scaling_pkg::RESULT_RST;
      supply_r <= scaling_pkg::RESULT_RST;
      current_r <= scaling_pkg::RESULT_RST;
    end
    else if (sample_valid_i)
    begin
      shunt_r <= shunt_sample_i; // RULE1
      supply_r <= supply_nxt; // RULE1 RULE8
      current_r <= current_nxt; // RULE6 RULE14
    end
  end

  // restoring divider, restarted by every new sample
  always_ff @(posedge clk_i)
  begin
    if (clear_all)
    begin
      state_r <= scaling_pkg::ST_IDLE;
      step_r <= '0;
      quot_r <= '0;
      rem_r <= '0;
    end
    else if (sample_valid_i)
    begin
      state_r <= scaling_pkg::ST_DIVIDE; // RULE6
      step_r <= '0;
      quot_r <= {1'b0, pwr_dividend}; // RULE14
      rem_r <= '0;
    end
    else
    begin
      case (state_r)
        scaling_pkg::ST_DIVIDE:
        begin
          quot_r <= quot_nxt;
          rem_r <= rem_nxt; // RULE13
          step_r <= 5'(step_r + 5'h01);
          if (last_step)
            state_r <= scaling_pkg::ST_IDLE;
        end
        default: state_r <= scaling_pkg::ST_IDLE;
      endcase
    end
  end

  // power step is fixed at 25 current steps; no power scale exists
  always_ff @(posedge clk_i)
  begin
    if (clear_all)
    begin
      power_r <= scaling_pkg::RESULT_RST;
      ready_r <= 1'b0;
    end
    else
    begin
      ready_r <= last_step && !sample_valid_i;
      if (last_step && !sample_valid_i)
        power_r <= sat_unsigned(quot_nxt[30:0]); // RULE2 RULE4 RULE5
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rdata_r <= scaling_pkg::UNMAPPED_READ;
    else if (reg_rd_i)
      rdata_r <= rd_mux;
  end

  assign reg_rdata_o = rdata_r;
  assign power_ready_o = ready_r;

  // checking helpers
  logic programmed_r;
  logic [15:0] pwr_ref_r;
  always_ff @(posedge clk_i)
  begin
    if (clear_all)
      programmed_r <= 1'b0;
    else if (wr_scale)
      programmed_r <= 1'b1;
  end
  wire signed [32:0] cur_ref_div = cur_prod / 33'sd2048;
  wire [15:0] cur_ref = (scale_r == 16'h0000) ? 16'h0000 : sat_signed(22'(cur_ref_div));
  always_ff @(posedge clk_i)
  begin
    if (sample_valid_i)
      pwr_ref_r <= sat_unsigned(31'(pwr_dividend / 31'd20000));
  end

  // cycles since the last sample, zero when no result is pending
  logic [5:0] since_r;
  always_ff @(posedge clk_i)
  begin
    if (clear_all)
      since_r <= 6'h00;
    else if (sample_valid_i)
      since_r <= 6'h01;
    else if (since_r != 6'h00 && since_r != 6'h21)
      since_r <= 6'(since_r + 6'h01);
    else
      since_r <= 6'h00;
  end

  sequence s_sample;
    sample_valid_i && nrst_i && !soft_rst;
  endsequence
  sequence s_done;
    since_r == 6'h21;
  endsequence

  a_shunt_capture: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE1
    s_sample |=> shunt_r == $past(shunt_sample_i))
    else $error("shunt result not captured");
  a_supply_msb: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE8
    supply_r[15] == 1'b0)
    else $error("supply result msb set");
  a_current_formula: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE3
    s_sample |=> current_r == $past(cur_ref))
    else $error("current result wrong");
  a_uncal_zero: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE5
    !programmed_r |-> current_r == 16'h0000 && power_r == 16'h0000)
    else $error("result nonzero before scale programmed");
  a_soft_reset: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE12
    soft_rst |=> scale_r == 16'h0000 && setup_r == 16'h4127)
    else $error("soft reset left scale or setup");
  a_power_refresh: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE6
    s_done |-> ready_r)
    else $error("power not refreshed 33 cycles after a sample");
  a_power_formula: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE4
    ready_r |-> power_r == pwr_ref_r)
    else $error("power result wrong");
  a_result_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE14
    !sample_valid_i && !soft_rst |=> $stable(current_r))
    else $error("current changed without a sample");

  // timing, hold, capture, zero scale, reset and register access
  a_ready_timing: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE6
    ready_r |-> s_done)
    else $error("power ready pulse out of place");
  a_ready_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE6
    ready_r |=> !ready_r)
    else $error("power ready longer than one cycle");
  a_divider_start: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE6
    s_sample |=> state_r == scaling_pkg::ST_DIVIDE && step_r == 5'h00)
    else $error("divider not restarted by a sample");
  a_power_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE14
    !ready_r && !$past(soft_rst) |-> $stable(power_r))
    else $error("power changed without a result");
  a_supply_capture: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE1 RULE7
    s_sample |=> supply_r == {1'b0, $past(supply_sample_i)})
    else $error("supply result not captured");
  a_zero_scale: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE5
    s_sample ##0 (scale_r == 16'h0000) |=> current_r == 16'h0000)
    else $error("current nonzero with zero scale");
  a_scale_write: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE11
    wr_scale |=> scale_r == $past(reg_wdata_i))
    else $error("scale write lost");
  a_scale_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE14
    wr_scale && !sample_valid_i |=> $stable(current_r))
    else $error("scale write altered stored current");
  a_setup_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_setup && !soft_rst |=> setup_r == $past(reg_wdata_i))
    else $error("setup write lost");
  a_soft_clear: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE12
    soft_rst |=> current_r == 16'h0000 && power_r == 16'h0000 && shunt_r == 16'h0000)
    else $error("soft reset left a result");
  a_hard_reset: assert property (@(posedge clk_i) // RULE12
    !nrst_i |=> scale_r == 16'h0000 && current_r == 16'h0000 && reg_rdata_o == 16'h0000)
    else $error("reset left scale, current or read data");
  a_shunt_readback: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE1
    reg_rd_i && reg_addr_i == scaling_pkg::OFS_SHUNT_DROP |=> reg_rdata_o == $past(shunt_r))
    else $error("shunt readback wrong");
  a_supply_read: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE8
    reg_rd_i && reg_addr_i == scaling_pkg::OFS_SUPPLY_LEVEL |=> reg_rdata_o[15] == 1'b0)
    else $error("supply readback msb set");
  a_current_read: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE3
    reg_rd_i && reg_addr_i == scaling_pkg::OFS_LOAD_CURRENT |=> reg_rdata_o == $past(current_r))
    else $error("current readback wrong");
  a_power_read: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE4
    reg_rd_i && reg_addr_i == scaling_pkg::OFS_LOAD_POWER |=> reg_rdata_o == $past(power_r))
    else $error("power readback wrong");
  a_scale_read: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE12
    reg_rd_i && reg_addr_i == scaling_pkg::OFS_SCALE_FACTOR |=> reg_rdata_o == $past(scale_r))
    else $error("scale readback wrong");
  a_unmapped_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    reg_rd_i && reg_addr_i > scaling_pkg::OFS_SCALE_FACTOR |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");

endmodule : current_power_scaling_engine

/* tb/host_model.sv */
`timescale 1ns/10ps
module host_model (
  input wire logic clk_i,
  output logic [7:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // step rounded up to whole milliamps
  function automatic real step_for(input real imax);
    return $ceil(imax / 32768.0 * 1000.0) / 1000.0;
  endfunction : step_for
  function automatic logic [15:0] scale_for(input real step, input real r);
    return 16'($rtoi(0.00512 / (step * r) + 0.5));
  endfunction : scale_for
  function automatic logic [15:0] trim(input logic [15:0] s, m, c);
    return 16'(32'(s) * 32'(m) / 32'(c));
  endfunction : trim
  // one access, launched on a falling edge, then one idle cycle
  task automatic access(input logic [7:0] a, input logic [15:0] d, input logic w);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = ~d;
    @(negedge clk_i);
  endtask : access
endmodule : host_model

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk_i, nrst_i, reg_wr_i, reg_rd_i, sample_valid_i, power_ready_o;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, shunt_sample_i, scale, cur;
  logic [14:0] supply_sample_i;
  logic [31:0] seed = 32'h10B20082;
  logic [15:0] rst_v[7] = '{16'h4127, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] notes[$];
  int err_count = 0;
  int tests_run = 0;
  host_model host_model_i (.clk_i(clk_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  current_power_scaling_engine current_power_scaling_engine_i (.clk_i(clk_i),
    .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .shunt_sample_i(shunt_sample_i),
    .supply_sample_i(supply_sample_i), .sample_valid_i(sample_valid_i),
    .reg_rdata_o(reg_rdata_o), .power_ready_o(power_ready_o));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] cur_of(input logic [15:0] sh, sc);
    longint p;
    p = longint'($signed(sh)) * longint'(sc) / 2048;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction : cur_of
  function automatic logic [15:0] pwr_of(input logic [15:0] c, input logic [14:0] su);
    longint m;
    m = longint'($signed(c));
    if (m < 0) m = -m;
    m = m * longint'(su) / 20000;
    return (m > 65535) ? 16'hFFFF : m[15:0];
  endfunction : pwr_of
  task automatic check(input string nm, input logic [15:0] e, s);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    notes.push_back(e);
    host_model_i.access(a, 16'h0000, 1'b0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_model_i.access(a, d, 1'b1);
  endtask : wr
  task automatic sample(input logic [15:0] sh, input logic [14:0] su);
    int n;
    shunt_sample_i = sh;
    supply_sample_i = su;
    sample_valid_i = 1'b1;
    @(negedge clk_i);
    sample_valid_i = 1'b0;
    n = 0;
    while (power_ready_o !== 1'b1 && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    check("power_ready_o", 16'h0001, {15'h0, power_ready_o});
  endtask : sample
  task automatic final_report();
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // read data registers on the read edge and is checked at the next falling edge
  always @(posedge clk_i) rd_d <= reg_rd_i;
  always @(negedge clk_i) if (rd_d === 1'b1) check("reg_rdata_o", notes.pop_front(), reg_rdata_o);
  initial
  begin
    #200000;
    err_count++;
    final_report();
  end
  initial
  begin
    nrst_i = 1'b0;
    shunt_sample_i = 16'h0000;
    supply_sample_i = 15'h0000;
    sample_valid_i = 1'b0;
    repeat (16) @(negedge clk_i);
    nrst_i = 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(i), rst_v[i]);
    sample(16'h1F40, 15'h2570);
    rd(8'h04, 16'h0000);
    rd(8'h03, 16'h0000);
    rd(8'h02, 16'h2570);
    wr(8'h01, 16'h1234);
    rd(8'h01, 16'h1F40);
    scale = host_model_i.scale_for(host_model_i.step_for(15.0), 0.002);
    wr(8'h05, scale);
    rd(8'h05, 16'h0A00);
    rd(8'h04, 16'h0000);
    sample(16'h1F40, 15'h2570);
    rd(8'h04, 16'h2710);
    rd(8'h03, 16'h12B8);
    shunt_sample_i = 16'h1F40;
    supply_sample_i = 15'h7FFF;
    sample_valid_i = 1'b1;
    @(negedge clk_i);
    sample_valid_i = 1'b0;
    repeat (5) @(negedge clk_i);
    sample(16'h1F40, 15'h1000);
    rd(8'h03, 16'h0800);
    scale = host_model_i.trim(scale, 16'd10100, 16'h2710);
    wr(8'h05, scale);
    sample(16'h1F40, 15'h2570);
    rd(8'h04, cur_of(16'h1F40, scale));
    fork
      wr(8'h05, 16'h0800);
      sample(16'hF000, 15'h0100);
    join
    rd(8'h04, cur_of(16'hF000, scale));
    repeat (20)
    begin
      seed = lfsr(seed);
      scale = seed[31:16];
      wr(8'h05, scale);
      seed = lfsr(seed);
      sample(seed[15:0], seed[30:16]);
      cur = cur_of(seed[15:0], scale);
      rd(8'h04, cur);
      rd(8'h03, pwr_of(cur, seed[30:16]));
    end
    wr(8'h00, 16'h0123);
    rd(8'h00, 16'h0123);
    wr(8'h00, 16'h8000);
    rd(8'h05, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h00, 16'h4127);
    wr(8'h05, 16'h0A00);
    sample(16'h1F40, 15'h2570);
    rd(8'h04, 16'h2710);
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    check("reg_rdata_o", 16'h0000, reg_rdata_o);
    rd(8'h05, 16'h0000);
    rd(8'h04, 16'h0000);
    final_report();
  end
endmodule : tb_top
